// [rtl/wdrc_timer.sv]
`timescale 1ns/10ps
`default_nettype none
package wdrc_pkg;
   localparam logic [11:0] WDRC_OFS_CAUSE = 12'h000;
   localparam logic [11:0] WDRC_OFS_CTRL = 12'h004;
   localparam int WDRC_RSV_HI = 7;
   localparam int WDRC_RSV_LO = 4;
   localparam int WDRC_CAUSE_WD = 3;
   localparam int WDRC_CAUSE_BO = 2;
   localparam int WDRC_CAUSE_EXT = 1;
   localparam int WDRC_CAUSE_POR = 0;
   localparam logic [3:0] WDRC_CAUSE_POR_VAL = 4'h1;
   localparam int WDRC_CTL_IF = 7;
   localparam int WDRC_CTL_IE = 6;
   localparam int WDRC_CTL_SEL3 = 5;
   localparam int WDRC_CTL_CE = 4;
   localparam int WDRC_CTL_RE = 3;
   localparam int WDRC_CTL_SEL_HI = 2;
   localparam int WDRC_CTL_SEL_LO = 0;
   localparam logic [3:0] WDRC_SEL_RESET = 4'h0;
   localparam logic [3:0] WDRC_SEL_MAX = 4'h9;
   localparam logic [1:0] WDRC_CE_LAST = 2'h3;
   localparam int WDRC_OSC_KHZ = 128;
   localparam logic [19:0] WDRC_TOUT_BASE = 20'h00800;
   localparam int WDRC_CNT_W = 20;
   typedef enum logic [1:0] {
      WDRC_STOP,
      WDRC_IRQ,
      WDRC_RST,
      WDRC_BOTH
   } wdrc_mode_e;
endpackage

module wdrc_timer
   import wdrc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic clear,
   input wire logic [WDRC_CNT_W-1:0] limit,
   output logic expire
);
   logic [WDRC_CNT_W-1:0] cnt_reg;
   logic hit;

   // a limit shortened below the count fires at once instead of wrapping the counter
   assign hit = tick && (cnt_reg >= limit - 20'h00001);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 20'h00000;
      end else if (clear || hit) begin
         cnt_reg <= 20'h00000;
      end else if (tick) begin
         cnt_reg <= cnt_reg + 20'h00001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         expire <= 1'b0;
      end else begin
         expire <= hit && !clear;
      end
   end
endmodule
`default_nettype wire

// [rtl/wdrc_top.sv]
`timescale 1ns/10ps
`default_nettype none
module wdrc_top
   import wdrc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wd_osc,
   input wire logic force_reset_fuse,
   input wire logic ext_pin_reset,
   input wire logic brownout_reset,
   input wire logic watchdog_restart_instr,
   input wire logic cpu_irq_global_en,
   input wire logic irq_vector_ack,
   output logic wd_irq_req,
   output logic wd_sys_reset
);
   logic [3:0] cause_reg;
   logic timeout_irq_flag;
   logic timeout_irq_enable;
   logic reset_on_timeout_enable;
   logic change_enable;
   logic [1:0] ce_cnt_reg;
   logic [3:0] timeout_select;
   logic osc_s1, osc_s2, osc_s3;
   logic fuse_s1, fuse_s2;
   logic ext_s1, ext_s2, ext_s3;
   logic bor_s1, bor_s2, bor_s3;
   logic [31:0] prdata_reg;
   logic osc_tick, ext_rise, bor_rise;
   logic wr_cause, wr_ctrl, rd_setup;
   logic reset_en_eff, expire, fire_irq, fire_rst, timer_clear;
   logic [WDRC_CNT_W-1:0] limit;
   logic [7:0] ctrl_view;
   wdrc_mode_e mode;

   function automatic logic [WDRC_CNT_W-1:0] tout_cycles(input logic [3:0] sel);
      if (sel > WDRC_SEL_MAX) begin
         tout_cycles = WDRC_TOUT_BASE;
      end else begin
         tout_cycles = WDRC_TOUT_BASE << sel;
      end
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == WDRC_OFS_CAUSE) || (a == WDRC_OFS_CTRL);
   endfunction

   // apb: zero wait states, read data latched in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);
   assign prdata = prdata_reg;
   assign rd_setup = psel && !penable && !pwrite;
   assign wr_cause = psel && penable && pwrite && (paddr == WDRC_OFS_CAUSE);
   assign wr_ctrl = psel && penable && pwrite && (paddr == WDRC_OFS_CTRL);

   // pins from other domains pass two flops before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_s3 <= 1'b0;
         fuse_s1 <= 1'b0;
         fuse_s2 <= 1'b0;
      end else begin
         osc_s1 <= wd_osc;
         osc_s2 <= osc_s1;
         osc_s3 <= osc_s2;
         fuse_s1 <= force_reset_fuse;
         fuse_s2 <= fuse_s1;
      end
   end

   // reset sources are watched from the power-on domain so they survive chip reset
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
         bor_s1 <= 1'b0;
         bor_s2 <= 1'b0;
         bor_s3 <= 1'b0;
      end else begin
         ext_s1 <= ext_pin_reset;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         bor_s1 <= brownout_reset;
         bor_s2 <= bor_s1;
         bor_s3 <= bor_s2;
      end
   end

   assign osc_tick = osc_s2 && !osc_s3;
   assign ext_rise = ext_s2 && !ext_s3;
   assign bor_rise = bor_s2 && !bor_s3;

   // cause flags: power-on sets bit 0 and clears the rest; set beats a write of zero
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         cause_reg <= WDRC_CAUSE_POR_VAL;
      end else begin
         if (wr_cause) begin
            cause_reg <= cause_reg & pwdata[3:0];
         end
         if (fire_rst) begin
            cause_reg[WDRC_CAUSE_WD] <= 1'b1;
         end
         if (bor_rise) begin
            cause_reg[WDRC_CAUSE_BO] <= 1'b1;
         end
         if (ext_rise) begin
            cause_reg[WDRC_CAUSE_EXT] <= 1'b1;
         end
      end
   end

   // fuse and watchdog cause both pin reset enable high
   assign reset_en_eff = reset_on_timeout_enable || cause_reg[WDRC_CAUSE_WD] || fuse_s2;

   always_comb begin
      if (fuse_s2) begin
         mode = WDRC_RST;
      end else begin
         mode = wdrc_mode_e'({reset_en_eff, timeout_irq_enable});
      end
   end

   always_comb begin
      fire_irq = 1'b0;
      fire_rst = 1'b0;
      case (mode)
         WDRC_STOP: begin
            fire_irq = 1'b0;
         end
         WDRC_IRQ: begin
            fire_irq = expire;
         end
         WDRC_RST: begin
            fire_rst = expire;
         end
         WDRC_BOTH: begin
            fire_rst = expire && timeout_irq_flag;
            fire_irq = expire && !timeout_irq_flag;
         end
         default: begin
            fire_rst = 1'b0;
         end
      endcase
   end

   // change window: opened only from closed, so a repeat write cannot stretch it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         change_enable <= 1'b0;
         ce_cnt_reg <= 2'h0;
      end else if (!change_enable) begin
         if (wr_ctrl && pwdata[WDRC_CTL_CE] && pwdata[WDRC_CTL_RE]) begin
            change_enable <= 1'b1;
            ce_cnt_reg <= 2'h0;
         end
      end else begin
         ce_cnt_reg <= ce_cnt_reg + 2'h1;
         if (ce_cnt_reg == WDRC_CE_LAST) begin
            change_enable <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_on_timeout_enable <= 1'b0;
      end else if (cause_reg[WDRC_CAUSE_WD]) begin
         reset_on_timeout_enable <= 1'b1;
      end else if (wr_ctrl) begin
         if (pwdata[WDRC_CTL_RE]) begin
            reset_on_timeout_enable <= 1'b1;
         end else if (change_enable) begin
            reset_on_timeout_enable <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_select <= WDRC_SEL_RESET;
      end else if (wr_ctrl && change_enable) begin
         timeout_select <= {pwdata[WDRC_CTL_SEL3], pwdata[WDRC_CTL_SEL_HI:WDRC_CTL_SEL_LO]};
      end
   end

   // a write in the same cycle as the vector keeps the written enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_irq_enable <= 1'b0;
      end else if (wr_ctrl) begin
         timeout_irq_enable <= pwdata[WDRC_CTL_IE];
      end else if (irq_vector_ack && mode == WDRC_BOTH) begin
         timeout_irq_enable <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_irq_flag <= 1'b0;
      end else if (fire_irq) begin
         timeout_irq_flag <= 1'b1;
      end else if (irq_vector_ack || (wr_ctrl && pwdata[WDRC_CTL_IF])) begin
         timeout_irq_flag <= 1'b0;
      end
   end

   assign wd_irq_req = timeout_irq_flag && timeout_irq_enable && cpu_irq_global_en;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_sys_reset <= 1'b0;
      end else begin
         wd_sys_reset <= fire_rst;
      end
   end

   assign limit = tout_cycles(timeout_select);
   assign timer_clear = watchdog_restart_instr || (mode == WDRC_STOP);

   wdrc_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .tick(osc_tick),
      .clear(timer_clear),
      .limit(limit),
      .expire(expire)
   );

   assign ctrl_view = {timeout_irq_flag, timeout_irq_enable, timeout_select[3], change_enable,
      reset_en_eff, timeout_select[2:0]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
      end else if (rd_setup) begin
         if (paddr == WDRC_OFS_CAUSE) begin
            prdata_reg <= {28'h0000000, cause_reg};
         end else if (paddr == WDRC_OFS_CTRL) begin
            prdata_reg <= {24'h000000, ctrl_view};
         end else begin
            prdata_reg <= 32'h00000000;
         end
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence ce_open;
      wr_ctrl && pwdata[WDRC_CTL_CE] && pwdata[WDRC_CTL_RE] && !change_enable;
   endsequence

   sequence ce_window;
      change_enable [*4] ##1 !change_enable;
   endsequence

   a_cause_rsv_zero: assert property (
      (psel && penable && !pwrite && paddr == WDRC_OFS_CAUSE) |-> prdata[7:4] == 4'h0)
      else $error("reserved cause bits read nonzero");
   a_wd_cause_set: assert property (wd_sys_reset |-> cause_reg[WDRC_CAUSE_WD])
      else $error("watchdog cause not set after watchdog reset");
   a_bo_cause_set: assert property (bor_rise |=> cause_reg[WDRC_CAUSE_BO])
      else $error("brown-out cause not set");
   a_ext_cause_set: assert property (ext_rise |=> cause_reg[WDRC_CAUSE_EXT])
      else $error("external cause not set");
   a_por_cause_hold: assert property (
      (cause_reg[WDRC_CAUSE_POR] && !wr_cause) |=> cause_reg[WDRC_CAUSE_POR])
      else $error("power-on cause lost without a write");
   a_irq_flag_set: assert property (
      (expire && mode == WDRC_IRQ) |=> timeout_irq_flag)
      else $error("interrupt flag not set on time-out");
   a_irq_ack_clear: assert property (
      (irq_vector_ack && !fire_irq) |=> !timeout_irq_flag)
      else $error("interrupt flag not cleared by vector");
   a_irq_req_gate: assert property (
      wd_irq_req |-> $past(fire_irq) || (timeout_irq_flag && cpu_irq_global_en))
      else $error("interrupt request without flag");
   a_fuse_forces_rst: assert property (
      (fuse_s2 && expire) |=> wd_sys_reset && !$rose(timeout_irq_flag))
      else $error("fuse did not force reset mode");
   a_combined_ack: assert property (
      (irq_vector_ack && mode == WDRC_BOTH && !wr_ctrl) |=> !timeout_irq_enable)
      else $error("combined mode vector left enable set");
   a_second_timeout: assert property (
      (mode == WDRC_BOTH && timeout_irq_flag && expire) |=> wd_sys_reset)
      else $error("pending second time-out did not reset");
   a_select_locked: assert property (
      !change_enable |=> $stable(timeout_select))
      else $error("prescaler changed outside window");
   a_ce_window: assert property (ce_open |=> ce_window)
      else $error("change window not four cycles");
   a_reset_en_held: assert property (cause_reg[WDRC_CAUSE_WD] |=> reset_on_timeout_enable)
      else $error("reset enable clear while watchdog cause set");
   a_rsv_sel_short: assert property (
      (timeout_select > WDRC_SEL_MAX) |-> limit == WDRC_TOUT_BASE)
      else $error("reserved select not shortest time-out");
   a_restart_quiet: assert property (
      watchdog_restart_instr |=> !expire)
      else $error("time-out right after restart");
endmodule
`default_nettype wire

// [tb/wdrc_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
   import wdrc_pkg::*;
   typedef struct {logic [11:0] a; logic w; logic [7:0] d; logic [7:0] e; logic r;} wdrc_row_s;
   localparam logic [11:0] CA = WDRC_OFS_CAUSE;
   localparam logic [11:0] CT = WDRC_OFS_CTRL;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic por_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic wd_osc = 1'h0;
   logic fuse = 1'h0;
   logic ext_rst = 1'h0;
   logic bo_rst = 1'h0;
   logic restart = 1'h0;
   logic gie = 1'h1;
   logic ack = 1'h0;
   logic wd_irq_req;
   logic wd_sys_reset;
   logic [31:0] rd;
   logic er;
   int miscompares = 0;
   int n_checks = 0;
   int n_rst = 0;
   int n;
   // ordinary register accesses: address, write, data, expected read, expected error
   wdrc_row_s rows [12] = '{
      '{CA, 1'h0, 8'h00, 8'h01, 1'h0},
      '{CA, 1'h1, 8'hfe, 8'h00, 1'h0},
      '{CA, 1'h0, 8'h00, 8'h00, 1'h0},
      '{CA, 1'h1, 8'hff, 8'h00, 1'h0},
      '{CA, 1'h0, 8'h00, 8'h00, 1'h0},
      '{CT, 1'h0, 8'h00, 8'h00, 1'h0},
      '{12'h008, 1'h1, 8'h55, 8'h00, 1'h1},
      '{12'h008, 1'h0, 8'h00, 8'h00, 1'h1},
      '{CT, 1'h1, 8'h08, 8'h00, 1'h0},
      '{CT, 1'h0, 8'h00, 8'h08, 1'h0},
      '{CT, 1'h1, 8'h00, 8'h00, 1'h0},
      '{CT, 1'h0, 8'h00, 8'h08, 1'h0}
   };

   wdrc_top u_wdrc_top (
      .pclk(pclk),
      .presetn(presetn),
      .por_n(por_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .wd_osc(wd_osc),
      .force_reset_fuse(fuse),
      .ext_pin_reset(ext_rst),
      .brownout_reset(bo_rst),
      .watchdog_restart_instr(restart),
      .cpu_irq_global_en(gie),
      .irq_vector_ack(ack),
      .wd_irq_req(wd_irq_req),
      .wd_sys_reset(wd_sys_reset)
   );

   always #10 pclk = ~pclk;

   // fast oscillator keeps a 2048-tick time-out near 8192 clocks
   always begin
      repeat (2) @(posedge pclk);
      wd_osc <= ~wd_osc;
   end

   always @(posedge pclk) begin
      if (wd_sys_reset === 1'h1) n_rst <= n_rst + 1;
   end

   task close_out;
      if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task hang;
      miscompares++;
      close_out;
   endtask

   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'h1 && k < 16);
      if (k >= 16) hang;
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task rdck(input logic [11:0] a, input logic [7:0] e, input string nm);
      apb(a, 1'h0, 8'h00);
      chk(nm, rd, {24'h000000, e});
   endtask

   task restart_pulse;
      @(posedge pclk);
      restart <= 1'h1;
      @(posedge pclk);
      restart <= 1'h0;
   endtask

   task ack_pulse;
      @(posedge pclk);
      ack <= 1'h1;
      gie <= 1'h1;
      @(posedge pclk);
      ack <= 1'h0;
   endtask

   // waits for the interrupt request, or for a new reset pulse when r is set
   task automatic wait_ev(input logic r, input int lim);
      int base;
      base = n_rst;
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while ((r ? n_rst == base : wd_irq_req !== 1'h1) && n < lim);
      if (n >= lim) hang;
   endtask

   initial begin
      repeat (100000) @(posedge pclk);
      hang;
   end

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      por_n <= 1'h1;
      foreach (rows[i]) begin
         apb(rows[i].a, rows[i].w, rows[i].d);
         if (!rows[i].w) chk("row rdata", rd, {24'h0, rows[i].e});
         chk("row pslverr", er, rows[i].r);
      end
      ext_rst <= 1'h1;
      repeat (4) @(posedge pclk);
      ext_rst <= 1'h0;
      rdck(CA, 8'h02, "ext cause");
      bo_rst <= 1'h1;
      repeat (4) @(posedge pclk);
      bo_rst <= 1'h0;
      rdck(CA, 8'h06, "brownout cause");
      presetn <= 1'h0;
      @(posedge pclk);
      presetn <= 1'h1;
      rdck(CA, 8'h06, "cause after chip reset");
      por_n <= 1'h0;
      @(posedge pclk);
      por_n <= 1'h1;
      rdck(CA, 8'h01, "cause after power-on");
      // window boundary: last accepted write four cycles after opening
      apb(CT, 1'h1, 8'h18);
      @(posedge pclk);
      apb(CT, 1'h1, 8'h21);
      rdck(CT, 8'h21, "late window write");
      apb(CT, 1'h1, 8'h18);
      repeat (2) @(posedge pclk);
      apb(CT, 1'h1, 8'h00);
      rdck(CT, 8'h29, "closed window write");
      apb(CT, 1'h1, 8'h18);
      apb(CT, 1'h1, 8'h00);
      rdck(CT, 8'h00, "window clear");
      // interrupt mode
      restart_pulse;
      apb(CT, 1'h1, 8'h40);
      wait_ev(1'h0, 9000);
      chk("irq period", (n > 8150 && n < 8215), 1'h1);
      chk("resets in irq mode", n_rst, 0);
      rdck(CT, 8'hc0, "irq flag");
      @(posedge pclk);
      gie <= 1'h0;
      @(posedge pclk);
      #1;
      chk("masked request", wd_irq_req, 1'h0);
      ack_pulse;
      rdck(CT, 8'h40, "vector clears flag");
      // combined mode
      restart_pulse;
      apb(CT, 1'h1, 8'h48);
      wait_ev(1'h0, 9000);
      chk("resets at first timeout", n_rst, 0);
      rdck(CT, 8'hc8, "combined flag");
      apb(CT, 1'h1, 8'hc8);
      rdck(CT, 8'h48, "flag write one");
      wait_ev(1'h0, 9000);
      wait_ev(1'h1, 9000);
      chk("reset one timeout later", (n > 8000), 1'h1);
      rdck(CA, 8'h09, "watchdog cause");
      ack_pulse;
      rdck(CT, 8'h08, "vector clears enable");
      apb(CT, 1'h1, 8'h18);
      apb(CT, 1'h1, 8'h00);
      rdck(CT, 8'h08, "enable held by cause");
      apb(CA, 1'h1, 8'h00);
      rdck(CA, 8'h00, "cause write zero");
      apb(CT, 1'h1, 8'h18);
      apb(CT, 1'h1, 8'h00);
      rdck(CT, 8'h00, "enable cleared");
      // fuse forces reset mode; reserved code falls back to 2048 ticks
      apb(CT, 1'h1, 8'h18);
      apb(CT, 1'h1, 8'h22);
      fuse <= 1'h1;
      repeat (3) @(posedge pclk);
      apb(CT, 1'h0, 8'h00);
      chk("fuse forces enable", rd[3], 1'h1);
      restart_pulse;
      wait_ev(1'h1, 9000);
      chk("reserved code period", (n > 8150 && n < 8215), 1'h1);
      repeat (12) begin
         repeat (1000) @(posedge pclk);
         restart_pulse;
      end
      chk("restart holds off reset", n_rst, 2);
      apb(CT, 1'h1, 8'h18);
      apb(CT, 1'h1, 8'h01);
      restart_pulse;
      wait_ev(1'h1, 17000);
      chk("code one period", (n > 16340 && n < 16410), 1'h1);
      close_out;
   end
endmodule
`default_nettype wire
